// ===== verilog/imu_output_data_registers.sv
// output register group: z acceleration, temperature, time stamp,
// update counter and x/y delta angles, read back by address
// assumes sensor samples and config words come from logic on mclk;
// only the sync pin is asynchronous
`timescale 1ns/1ns

module imu_output_data_registers
    import imu_out_pkg::*;
#(
    parameter int STAMP_CYCLES = STAMP_TICK_CYCLES
)
(
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    input  wire logic                     reset_cmd,
    input  wire logic                     sample_strobe,
    input  wire logic signed [RATE_W-1:0] rate_x,
    input  wire logic signed [RATE_W-1:0] rate_y,
    input  wire logic [31:0]              accel_z,
    input  wire logic [WORD_W-1:0]        temperature,
    input  wire logic                     sync_pin,
    input  wire logic [WORD_W-1:0]        miscellaneous_control,
    input  wire logic [WORD_W-1:0]        decimation_setting,
    input  wire logic                     rd_en,
    input  wire logic [ADDR_W-1:0]        rd_addr,
    output logic      [WORD_W-1:0]        rd_data,
    output logic                          sample_ready_output
);
    // output words
    logic [WORD_W-1:0] accel_z_fraction_reg;
    logic [WORD_W-1:0] accel_z_upper_reg;
    logic [WORD_W-1:0] die_temperature_reg;
    logic [WORD_W-1:0] sync_elapsed_time_reg;
    logic [WORD_W-1:0] update_counter_reg;
    logic [31:0]       angle_x_reg;
    logic [31:0]       angle_y_reg;
    logic [WORD_W-1:0] rd_data_next;
    logic              ready_reg;

    // pacing and time base
    logic [WORD_W-1:0] samp_cnt_reg;
    logic [WORD_W-1:0] samp_cnt_next;
    logic [15:0]       presc_reg;
    logic [15:0]       presc_next;
    logic [WORD_W-1:0] elapsed_reg;
    logic [WORD_W-1:0] elapsed_next;
    logic              sync_meta_reg;
    logic              sync_sync_reg;
    logic              sync_last_reg;

    wire               last_sample;
    wire               update;
    wire               scaled_mode;
    wire               sync_edge;
    wire               stamp_tick;
    wire [WORD_W-1:0]  stamp_value;
    wire [WORD_W-1:0]  counter_next;
    wire [ADDR_W-1:0]  word_addr;

    angle_if axis_x ();
    angle_if axis_y ();

    // pacing: final sample of each decimated interval triggers the update
    assign last_sample = samp_cnt_reg == decimation_setting;
    assign update      = sample_strobe && last_sample;
    assign samp_cnt_next = reset_cmd ? WORD_ZERO :
                           !sample_strobe ? samp_cnt_reg :
                           last_sample ? WORD_ZERO : samp_cnt_reg + 16'h0001;

    // sync edge on the resynchronised pin, rising edge only;
    // a pin idling high gives one false edge after reset, which only
    // restarts the time base and so is left alone
    assign scaled_mode = miscellaneous_control[SYNC_MODE_LSB +: SYNC_MODE_W]
                         == SYNC_SCALED;
    assign sync_edge   = sync_sync_reg && !sync_last_reg;
    assign stamp_tick  = presc_reg == 16'(STAMP_CYCLES - 1);
    assign presc_next  = (!scaled_mode || sync_edge || stamp_tick) ? 16'h0000
                         : presc_reg + 16'h0001;
    // saturates rather than wraps, a stalled sync reads as a large age
    assign elapsed_next = (!scaled_mode || sync_edge) ? WORD_ZERO :
                          (stamp_tick && elapsed_reg != WORD_MAX)
                          ? elapsed_reg + 16'h0001 : elapsed_reg;
    assign stamp_value  = scaled_mode ? elapsed_reg : WORD_ZERO;

    // counter wraps naturally at 16 bits
    assign counter_next = update_counter_reg + 16'h0001;

    // integrator hookup, both axes share pacing
    // reset_cmd clears both accumulators and the carried previous rate
    assign axis_x.sample_valid = sample_strobe;
    assign axis_x.last_sample  = last_sample;
    assign axis_x.clear        = reset_cmd;
    assign axis_x.rate         = rate_x;
    assign axis_y.sample_valid = sample_strobe;
    assign axis_y.last_sample  = last_sample;
    assign axis_y.clear        = reset_cmd;
    assign axis_y.rate         = rate_y;

    angle_integrator integ_x (
        .mclk  (mclk),
        .rst_n (rst_n),
        .port  (axis_x.integ)
    );

    angle_integrator integ_y (
        .mclk  (mclk),
        .rst_n (rst_n),
        .port  (axis_y.integ)
    );

    // read decode; odd byte addresses reach the same word
    assign word_addr = {rd_addr[ADDR_W-1:1], 1'b0};
    always_comb
    begin
        unique case (word_addr)
            OFS_ACCEL_Z_FRACTION:  rd_data_next = accel_z_fraction_reg;
            OFS_ACCEL_Z_UPPER:     rd_data_next = accel_z_upper_reg;
            OFS_DIE_TEMPERATURE:   rd_data_next = die_temperature_reg;
            OFS_SYNC_ELAPSED_TIME: rd_data_next = sync_elapsed_time_reg;
            OFS_UPDATE_COUNTER:    rd_data_next = update_counter_reg;
            OFS_ANGLE_X_FRACTION:  rd_data_next = angle_x_reg[15:0];
            OFS_ANGLE_X_UPPER:     rd_data_next = angle_x_reg[31:16];
            OFS_ANGLE_Y_FRACTION:  rd_data_next = angle_y_reg[15:0];
            OFS_ANGLE_Y_UPPER:     rd_data_next = angle_y_reg[31:16];
            default:               rd_data_next = WORD_ZERO;
        endcase
    end

    // sync pin synchroniser; the second and third stages feed the edge detect
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sync_meta_reg <= 1'b0;
            sync_sync_reg <= 1'b0;
            sync_last_reg <= 1'b0;
        end
        else
        begin
            sync_meta_reg <= sync_pin;
            sync_sync_reg <= sync_meta_reg;
            sync_last_reg <= sync_sync_reg;
        end
    end

    // time base and decimation count
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            presc_reg    <= 16'h0000;
            elapsed_reg  <= WORD_ZERO;
            samp_cnt_reg <= WORD_ZERO;
        end
        else
        begin
            presc_reg    <= presc_next;
            elapsed_reg  <= elapsed_next;
            samp_cnt_reg <= samp_cnt_next;
        end
    end

    // all words load on one edge so word pairs stay coherent
    // angles take the running totals, which already hold this sample
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            accel_z_fraction_reg  <= WORD_ZERO;
            accel_z_upper_reg     <= WORD_ZERO;
            die_temperature_reg   <= WORD_ZERO;
            sync_elapsed_time_reg <= WORD_ZERO;
            angle_x_reg           <= 32'h00000000;
            angle_y_reg           <= 32'h00000000;
        end
        else if (update)
        begin
            accel_z_fraction_reg  <= accel_z[15:0];
            accel_z_upper_reg     <= accel_z[31:16];
            die_temperature_reg   <= temperature;
            sync_elapsed_time_reg <= stamp_value;
            angle_x_reg           <= angle_scale(axis_x.total);
            angle_y_reg           <= angle_scale(axis_y.total);
        end
    end

    // update counter, ready pulse and read data
    // read data holds between reads so a slow host may fetch it late
    always_ff @(posedge mclk)
    begin
        if (!rst_n || reset_cmd)
            update_counter_reg <= WORD_ZERO;
        else if (update)
            update_counter_reg <= counter_next;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ready_reg <= 1'b0;
            rd_data   <= WORD_ZERO;
        end
        else
        begin
            ready_reg <= update;
            rd_data   <= rd_en ? rd_data_next : rd_data;
        end
    end

    assign sample_ready_output = ready_reg;

    // checks
    cnt_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
        update && !reset_cmd |=> update_counter_reg == $past(update_counter_reg) + 16'h0001)
        else $error("update counter did not step by one");

    cnt_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
        reset_cmd |=> update_counter_reg == WORD_ZERO)
        else $error("update counter not cleared by reset command");

    accel_pair_a: assert property (@(posedge mclk) disable iff (!rst_n)
        update |=> {accel_z_upper_reg, accel_z_fraction_reg} == $past(accel_z)
                   && sample_ready_output)
        else $error("acceleration words not loaded together");

    temp_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
        update |=> die_temperature_reg == $past(temperature))
        else $error("temperature word not loaded on update");

    stamp_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
        update && !scaled_mode |=> sync_elapsed_time_reg == WORD_ZERO)
        else $error("time stamp moved outside scaled sync mode");

    stamp_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
        update && scaled_mode |=> sync_elapsed_time_reg == $past(elapsed_reg))
        else $error("time stamp not the age of the final sample");

    stamp_restart_a: assert property (@(posedge mclk) disable iff (!rst_n)
        scaled_mode && sync_edge ##1 scaled_mode |-> elapsed_reg == WORD_ZERO
        && presc_reg == 16'h0000)
        else $error("sync edge did not restart the time base");

    dec_span_a: assert property (@(posedge mclk) disable iff (!rst_n)
        update |=> samp_cnt_reg == WORD_ZERO)
        else $error("decimation count not restarted after update");

    angle_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
        update |=> angle_x_reg == angle_scale($past(axis_x.total))
                   && angle_y_reg == angle_scale($past(axis_y.total)))
        else $error("delta angle words not loaded from integrator");

    ready_only_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !update |=> !sample_ready_output)
        else $error("ready pulse without an update");

    // read port and pacing checks
    cnt_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_en && word_addr == OFS_UPDATE_COUNTER |=> rd_data == $past(update_counter_reg))
        else $error("counter word not returned on read");

    rd_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !rd_en |=> rd_data == $past(rd_data))
        else $error("read data changed without a read");

    dec_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        sample_strobe && !last_sample && !reset_cmd
        |=> update_counter_reg == $past(update_counter_reg) && !sample_ready_output)
        else $error("update before the final sample of the interval");

    // time base checks
    stamp_tick_a: assert property (@(posedge mclk) disable iff (!rst_n)
        scaled_mode && !sync_edge && stamp_tick && elapsed_reg != WORD_MAX
        |=> elapsed_reg == $past(elapsed_reg) + 16'h0001)
        else $error("time stamp did not advance on its tick");

    mode_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !scaled_mode |=> elapsed_reg == WORD_ZERO && presc_reg == 16'h0000)
        else $error("time base ran outside scaled sync mode");

    // main scenarios
    update_c:  cover property (@(posedge mclk) disable iff (!rst_n) update);
    wrap_c:    cover property (@(posedge mclk) disable iff (!rst_n)
        update && update_counter_reg == WORD_MAX);
    sync_c:    cover property (@(posedge mclk) disable iff (!rst_n)
        scaled_mode && sync_edge ##[1:100] update);
    cmd_c:     cover property (@(posedge mclk) disable iff (!rst_n) reset_cmd);
    dec_c:     cover property (@(posedge mclk) disable iff (!rst_n)
        update && decimation_setting != WORD_ZERO);

endmodule

// ===== common/imu_out_pkg.sv
// package for the inertial output register group: offsets, fields, scaling
// assumes a 250 MHz mclk and 16-bit rate samples at 0.1 deg/s per count
package imu_out_pkg;

    // register byte offsets (word pairs, bit 0 of the address is ignored)
    localparam logic [6:0] OFS_ACCEL_Z_FRACTION   = 7'h18;
    localparam logic [6:0] OFS_ACCEL_Z_UPPER      = 7'h1a;
    localparam logic [6:0] OFS_DIE_TEMPERATURE    = 7'h1c;
    localparam logic [6:0] OFS_SYNC_ELAPSED_TIME  = 7'h1e;
    localparam logic [6:0] OFS_UPDATE_COUNTER     = 7'h22;
    localparam logic [6:0] OFS_ANGLE_X_FRACTION   = 7'h24;
    localparam logic [6:0] OFS_ANGLE_X_UPPER      = 7'h26;
    localparam logic [6:0] OFS_ANGLE_Y_FRACTION   = 7'h28;
    localparam logic [6:0] OFS_ANGLE_Y_UPPER      = 7'h2a;

    localparam int         ADDR_W       = 7;
    localparam int         WORD_W       = 16;
    localparam int         RATE_W       = 16;
    localparam int         ACC_W        = 34; // 65536 full-scale pairs, no wrap
    localparam logic [15:0] WORD_ZERO   = 16'h0000;
    localparam logic [15:0] WORD_MAX    = 16'hffff;

    // sync mode field of the miscellaneous control word
    localparam int         SYNC_MODE_LSB = 2;
    localparam int         SYNC_MODE_W   = 3;
    localparam logic [2:0] SYNC_SCALED   = 3'h2;

    // time stamp resolution and its cycle count at the mclk rate
    localparam real        STAMP_LSB_US      = 49.02;
    localparam real        CLK_MHZ           = 250.0;
    localparam int         STAMP_TICK_CYCLES = int'(STAMP_LSB_US * CLK_MHZ);

    // delta angle scaling: sum of rate pairs -> 32-bit angle word
    localparam longint     SAMPLE_RATE_SPS     = 2000;
    localparam longint     RATE_COUNTS_PER_DPS = 10;
    localparam longint     ANGLE_RANGE_DEG     = 2160;
    localparam int         ANGLE_FRAC_BITS     = 31;
    localparam int         GAIN_SHIFT          = 16;
    localparam logic signed [63:0] ANGLE_GAIN =
        (64'sd1 <<< (ANGLE_FRAC_BITS + GAIN_SHIFT)) /
        (64'sd2 * SAMPLE_RATE_SPS * RATE_COUNTS_PER_DPS * ANGLE_RANGE_DEG);
    localparam logic signed [63:0] ANGLE_POS_MAX = 64'sh000000007fffffff;
    localparam logic signed [63:0] ANGLE_NEG_MIN = -64'sh0000000080000000;

    // fixed-point scale of an integrated pair sum, saturating at full range
    function automatic logic [31:0] angle_scale(input logic signed [ACC_W-1:0] sum);
        logic signed [63:0] prod;
        logic signed [63:0] shifted;
        prod    = 64'(sum) * ANGLE_GAIN;
        shifted = prod >>> GAIN_SHIFT;
        if (shifted > ANGLE_POS_MAX)
            return 32'h7fffffff;
        else if (shifted < ANGLE_NEG_MIN)
            return 32'h80000000;
        else
            return shifted[31:0];
    endfunction

endpackage

// ===== common/angle_if.sv
// one axis of rate samples into an integrator and its running total back
// assumes both ends run on the same mclk
`timescale 1ns/1ns
interface angle_if;
    import imu_out_pkg::*;
    logic                     sample_valid;
    logic                     last_sample;
    logic                     clear;
    logic signed [RATE_W-1:0] rate;
    logic signed [ACC_W-1:0]  total;

    modport drive (output sample_valid, output last_sample, output clear,
                   output rate, input total);
    modport integ (input sample_valid, input last_sample, input clear,
                   input rate, output total);
endinterface

// ===== verilog/angle_integrator.sv
// trapezoidal integrator for one axis of angular rate
// assumes samples arrive as single-cycle strobes on mclk
`timescale 1ns/1ns
module angle_integrator
    import imu_out_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    angle_if.integ   port
);
    logic signed [ACC_W-1:0]  acc_reg;
    logic signed [ACC_W-1:0]  acc_next;
    logic signed [RATE_W-1:0] prev_reg;
    logic signed [RATE_W-1:0] prev_next;
    wire  signed [ACC_W-1:0]  pair_sum;

    // pair of this and previous sample; previous carries across updates
    assign pair_sum   = ACC_W'(port.rate) + ACC_W'(prev_reg);
    assign port.total = acc_reg + pair_sum;
    // restart at every final sample so each result covers one interval
    assign acc_next   = port.clear ? '0 :
                        !port.sample_valid ? acc_reg :
                        port.last_sample ? '0 : port.total;
    assign prev_next  = port.clear ? '0 :
                        port.sample_valid ? port.rate : prev_reg;

    // accumulator and previous sample
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            acc_reg  <= '0;
            prev_reg <= '0;
        end
        else
        begin
            acc_reg  <= acc_next;
            prev_reg <= prev_next;
        end
    end

    acc_pair_sum_a: assert property (@(posedge mclk) disable iff (!rst_n)
        port.sample_valid && !port.last_sample && !port.clear
        |=> acc_reg == $past(acc_reg) + ACC_W'($past(port.rate)) + ACC_W'($past(prev_reg)))
        else $error("accumulator did not add the rate pair");

    acc_restart_a: assert property (@(posedge mclk) disable iff (!rst_n)
        port.sample_valid && port.last_sample |=> acc_reg == '0)
        else $error("accumulator not restarted after final sample");

endmodule

// ===== bench/imu_host_model.sv
// host side of the output register group: issues word reads, times ready pulses
// assumes the register read port of the design and a shared mclk
`timescale 1ns/1ns
module imu_host_model
    import imu_out_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic [WORD_W-1:0] rd_data,
    input  wire logic              sample_ready_output,
    output logic                   rd_en,
    output logic [ADDR_W-1:0]      rd_addr
);
    logic [31:0] period_reg;
    logic [31:0] last_period_reg;

    initial
    begin
        rd_en   = 1'b0;
        rd_addr = 7'h00;
    end

    // one read: request held for one edge, data taken after it
    task automatic read_word(input logic [ADDR_W-1:0] addr, output logic [WORD_W-1:0] data);
        @(negedge mclk);
        rd_en   = 1'b1;
        rd_addr = addr;
        @(negedge mclk);
        data  = rd_data;
        rd_en = 1'b0;
    endtask

    // ready period in mclk cycles less one, counted from one ready pulse to the next
    always_ff @(posedge mclk)
    begin
        period_reg <= sample_ready_output ? 32'h0 : period_reg + 32'h1;
        if (sample_ready_output)
            last_period_reg <= period_reg;
    end
endmodule

// ===== bench/imu_output_data_registers_tb.sv
// self-checking bench for the output register group
// assumes the host model in bench/ and a shortened time stamp tick
`timescale 1ns/1ns
`define CHK(got, exp) \
    begin \
        checked++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module imu_output_data_registers_tb;
    import imu_out_pkg::*;

    localparam int     STAMP_SIM = 8;
    localparam longint GAIN      = (64'sd1 <<< (ANGLE_FRAC_BITS + GAIN_SHIFT)) /
        (64'sd2 * SAMPLE_RATE_SPS * RATE_COUNTS_PER_DPS * ANGLE_RANGE_DEG);

    typedef struct packed
    {
        logic signed [15:0] rx;
        logic signed [15:0] ry;
        logic [31:0]        acc;
        logic [15:0]        temp;
    } row_type;

    logic                     mclk;
    logic                     rst_n;
    logic                     reset_cmd;
    logic                     sample_strobe;
    logic signed [RATE_W-1:0] rate_x;
    logic signed [RATE_W-1:0] rate_y;
    logic [31:0]              accel_z;
    logic [WORD_W-1:0]        temperature;
    logic                     sync_pin;
    logic [WORD_W-1:0]        miscellaneous_control;
    logic [WORD_W-1:0]        decimation_setting;
    logic                     rd_en;
    logic [ADDR_W-1:0]        rd_addr;
    logic [WORD_W-1:0]        rd_data;
    logic                     sample_ready_output;
    int                       fail_count;
    int                       checked;
    longint                   prev_x;
    longint                   prev_y;
    longint                   sum_x;
    longint                   sum_y;
    logic [15:0]              exp_cnt;
    logic [15:0]              v;
    logic [15:0]              v2;
    row_type                  rows [4];

    imu_output_data_registers #(.STAMP_CYCLES(STAMP_SIM)) i_imu_output_data_registers (
        .mclk(mclk), .rst_n(rst_n), .reset_cmd(reset_cmd), .sample_strobe(sample_strobe),
        .rate_x(rate_x), .rate_y(rate_y), .accel_z(accel_z), .temperature(temperature),
        .sync_pin(sync_pin), .miscellaneous_control(miscellaneous_control),
        .decimation_setting(decimation_setting), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data(rd_data), .sample_ready_output(sample_ready_output));

    imu_host_model i_imu_host_model (
        .mclk(mclk), .rd_data(rd_data), .sample_ready_output(sample_ready_output),
        .rd_en(rd_en), .rd_addr(rd_addr));

    // 250 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // reference scaling of a pair sum, saturating like a 32-bit signed word
    function automatic logic [31:0] exp_angle(input longint sum);
        longint p;
        p = (sum * GAIN) >>> GAIN_SHIFT;
        if (p > 64'sh7fffffff)
            return 32'h7fffffff;
        if (p < -64'sh80000000)
            return 32'h80000000;
        return p[31:0];
    endfunction

    // one sample; ready is looked at in the cycle after the taking edge
    task automatic strobe(input row_type r, input logic exp_ready);
        @(negedge mclk);
        sample_strobe = 1'b1;
        rate_x        = r.rx;
        rate_y        = r.ry;
        accel_z       = r.acc;
        temperature   = r.temp;
        sum_x         = sum_x + longint'(r.rx) + prev_x;
        sum_y         = sum_y + longint'(r.ry) + prev_y;
        prev_x        = longint'(r.rx);
        prev_y        = longint'(r.ry);
        @(negedge mclk);
        sample_strobe = 1'b0;
        `CHK(sample_ready_output, exp_ready)
    endtask

    // read every word of one update except the time stamp and compare
    task automatic check_words(input logic [31:0] acc, input logic [15:0] temp);
        logic [31:0] ax;
        logic [31:0] ay;
        ax = exp_angle(sum_x);
        ay = exp_angle(sum_y);
        i_imu_host_model.read_word(OFS_ACCEL_Z_UPPER, v);
        `CHK(v, acc[31:16])
        i_imu_host_model.read_word(OFS_ACCEL_Z_FRACTION, v);
        `CHK(v, acc[15:0])
        i_imu_host_model.read_word(OFS_DIE_TEMPERATURE, v);
        `CHK(v, temp)
        i_imu_host_model.read_word(OFS_UPDATE_COUNTER, v);
        `CHK(v, exp_cnt)
        i_imu_host_model.read_word(OFS_ANGLE_X_UPPER, v);
        `CHK(v, ax[31:16])
        i_imu_host_model.read_word(OFS_ANGLE_X_FRACTION, v);
        `CHK(v, ax[15:0])
        i_imu_host_model.read_word(OFS_ANGLE_Y_UPPER, v);
        `CHK(v, ay[31:16])
        i_imu_host_model.read_word(OFS_ANGLE_Y_FRACTION, v);
        `CHK(v, ay[15:0])
        sum_x = 0;
        sum_y = 0;
    endtask

    task automatic end_of_test;
        $display("mismatches %0d of %0d comparisons", fail_count, checked);
        if (fail_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // watchdog, sized for the counter wrap run plus margin
    initial
    begin
        #400000;
        fail_count++;
        end_of_test;
    end

    initial
    begin
        rst_n                 = 1'b0;
        reset_cmd             = 1'b0;
        sample_strobe         = 1'b0;
        sync_pin              = 1'b0;
        rate_x                = 16'sh0000;
        rate_y                = 16'sh0000;
        accel_z               = 32'h0;
        temperature           = 16'h0000;
        miscellaneous_control = 16'h0000;
        decimation_setting    = 16'h0000;
        fail_count            = 0;
        checked               = 0;
        prev_x                = 0;
        prev_y                = 0;
        sum_x                 = 0;
        sum_y                 = 0;
        exp_cnt = 16'h0000;
        rows = '{'{16'sh0064, 16'shff9c, 32'h7d00_0000, 16'h0352},
                 '{16'sh7fff, 16'sh8000, 32'h8300_0000, 16'hff06},
                 '{16'sh7fff, 16'sh8000, 32'h0000_0001, 16'h0000},
                 '{16'sh0000, 16'sh0001, 32'hffff_fffe, 16'h00fa}};
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        i_imu_host_model.read_word(OFS_UPDATE_COUNTER, v);
        `CHK(v, WORD_ZERO)
        // ordinary updates, one per sample
        foreach (rows[i])
        begin
            strobe(rows[i], 1'b1);
            exp_cnt++;
            check_words(rows[i].acc, rows[i].temp);
            i_imu_host_model.read_word(OFS_SYNC_ELAPSED_TIME, v);
            `CHK(v, WORD_ZERO)
        end
        // decimation 2: three samples, one update, fresh accumulation
        decimation_setting = 16'h0002;
        strobe('{16'sd1000, -16'sd700, 32'h0001_8000, 16'h00fa}, 1'b0);
        strobe('{16'sd2000, -16'sd700, 32'h0002_8000, 16'h00fb}, 1'b0);
        strobe('{16'sd3000, -16'sd900, 32'h0003_8000, 16'h00fc}, 1'b1);
        exp_cnt++;
        check_words(32'h0003_8000, 16'h00fc);
        // unmapped places read as zero
        i_imu_host_model.read_word(7'h20, v);
        `CHK(v, WORD_ZERO)
        i_imu_host_model.read_word(7'h2c, v);
        `CHK(v, WORD_ZERO)
        // scaled sync: stamp grows by 10 ticks over 80 cycles between updates
        decimation_setting    = 16'h0000;
        miscellaneous_control = 16'h0008;
        @(negedge mclk);
        sync_pin = 1'b1;
        repeat (39) @(negedge mclk);
        strobe(rows[3], 1'b1);
        i_imu_host_model.read_word(OFS_SYNC_ELAPSED_TIME, v);
        `CHK((v >= 16'h0003 && v <= 16'h0006), 1'b1)
        sync_pin = 1'b0;
        repeat (76) @(negedge mclk);
        strobe(rows[3], 1'b1);
        i_imu_host_model.read_word(OFS_SYNC_ELAPSED_TIME, v2);
        `CHK(16'(v2 - v), 16'h000a)
        // ready pulses 80 cycles apart, which the host counts as 79
        `CHK(i_imu_host_model.last_period_reg, 32'h0000004f)
        // reset command clears the counter
        miscellaneous_control = 16'h0000;
        @(negedge mclk);
        reset_cmd = 1'b1;
        @(negedge mclk);
        reset_cmd = 1'b0;
        i_imu_host_model.read_word(OFS_UPDATE_COUNTER, v);
        `CHK(v, WORD_ZERO)
        // back-to-back samples up to the counter's top, then one more wraps it
        @(negedge mclk);
        sample_strobe = 1'b1;
        rate_x = 16'sh0000;
        rate_y = 16'sh0000;
        repeat (65535) @(negedge mclk);
        sample_strobe = 1'b0;
        i_imu_host_model.read_word(OFS_UPDATE_COUNTER, v);
        `CHK(v, WORD_MAX)
        strobe('{16'sh0000, 16'sh0000, 32'h0, 16'h0000}, 1'b1);
        i_imu_host_model.read_word(OFS_UPDATE_COUNTER, v);
        `CHK(v, WORD_ZERO)
        // mid-run reset after a loaded sample: read data and words fall to zero
        strobe(rows[0], 1'b1);
        i_imu_host_model.read_word(OFS_DIE_TEMPERATURE, v);
        `CHK(v, rows[0].temp)
        @(negedge mclk);
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        `CHK(rd_data, WORD_ZERO)
        `CHK(sample_ready_output, 1'b0)
        rst_n  = 1'b1;
        prev_x = 0;
        prev_y = 0;
        sum_x  = 0;
        sum_y  = 0;
        i_imu_host_model.read_word(OFS_DIE_TEMPERATURE, v);
        `CHK(v, WORD_ZERO)
        i_imu_host_model.read_word(OFS_UPDATE_COUNTER, v);
        `CHK(v, WORD_ZERO)
        // first sample after reset pairs with a zero previous rate
        exp_cnt = 16'h0001;
        strobe(rows[1], 1'b1);
        check_words(rows[1].acc, rows[1].temp);
        end_of_test;
    end
endmodule
